// >>> ipsp_pkg.sv
// constants and types shared by the peripheral space block
package ipsp_pkg;

   // ======================================================
   // pointer values
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] PTR_WDATA_MSB = 8'h07;
   localparam logic [7:0] PTR_RDATA_MSB = 8'h17;
   localparam logic [7:0] PTR_LAST = 8'hFF;
   localparam logic [7:0] PTR_WRAP = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic [7:0] PTR_MBOUT_MSB = 8'h93;
   localparam logic [7:0] PTR_MBIN_MSB = 8'h97;

   // ======================================================
   // register offsets in the 256-byte space
   localparam logic [7:0] OFS_WADDR = 8'h00;
   localparam logic [7:0] OFS_WDATA = 8'h04;
   localparam logic [7:0] OFS_RADDR = 8'h10;
   localparam logic [7:0] OFS_RDATA = 8'h14;
   localparam logic [7:0] OFS_ASTAT = 8'h20;
   localparam logic [7:0] OFS_ACTRL = 8'h24;
   localparam logic [7:0] OFS_SUMM = 8'h80;
   localparam logic [7:0] OFS_AEN = 8'h84;
   localparam logic [7:0] OFS_MBOUT = 8'h90;
   localparam logic [7:0] OFS_MBIN = 8'h94;

   // ======================================================
   // access control fields and reset values
   localparam int CTRL_WR_EN_BIT = 0;
   localparam int CTRL_RD_EN_BIT = 1;
   localparam int CTRL_AUTO_INC_BIT = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

   // ======================================================
   // access status fields
   localparam int STAT_ALERT_BIT = 0;
   localparam int STAT_WR_OK_BIT = 1;
   localparam int STAT_RD_OK_BIT = 2;
   localparam int STAT_BUS_ERR_BIT = 3;
   localparam int STAT_DENIED_BIT = 4;
   localparam int STAT_MBOUT_FULL_BIT = 5;
   localparam int STAT_MBIN_FULL_BIT = 6;

   // internal bus engine states
   typedef enum logic {ENG_IDLE, ENG_BUS} ipsp_eng_e;

endpackage : ipsp_pkg

// >>> ipsp_rbus_if.sv
// carrier between the peripheral space core and its register bus engine
`timescale 1ns/10ps
interface ipsp_rbus_if;
   logic start;
   logic we;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic done;
   logic err;
   logic [31:0] rdata;

   modport core (output start, output we, output addr, output wdata,
                 input done, input err, input rdata);
   modport eng (input start, input we, input addr, input wdata,
                output done, output err, output rdata);
endinterface : ipsp_rbus_if

// >>> ipsp_rbus_eng.sv
// internal register bus master: one access per start, done pulse on finish
`timescale 1ns/10ps
module ipsp_rbus_eng
   import ipsp_pkg::*;
(
   // clock and synchronised reset
   input wire logic clk,
   input wire logic rst_core_n,
   // request side
   ipsp_rbus_if.eng bus,
   // internal register bus
   output logic rb_req,
   output logic rb_we,
   output logic [31:0] rb_addr,
   output logic [31:0] rb_wdata,
   input wire logic rb_ack,
   input wire logic rb_err,
   input wire logic [31:0] rb_rdata
);

   ipsp_eng_e state_r;
   ipsp_eng_e state_nxt;
   logic we_r;
   logic [31:0] addr_r;
   logic [31:0] wdata_r;
   logic done_r;
   logic err_r;
   logic [31:0] rdata_r;
   logic finish;

   // ======================================================
   // state sequencing; a start while busy cannot occur, core blocks it
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ENG_IDLE: if (bus.start) state_nxt = ENG_BUS;
         ENG_BUS: if (rb_ack) state_nxt = ENG_IDLE;
      endcase
   end

   assign finish = (state_r == ENG_BUS) & rb_ack;

   // request held until the slave acknowledges
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         state_r <= ENG_IDLE;
         we_r <= 1'b0;
         addr_r <= WORD_RESET;
         wdata_r <= WORD_RESET;
         done_r <= 1'b0;
         err_r <= 1'b0;
         rdata_r <= WORD_RESET;
      end else begin
         state_r <= state_nxt;
         if (bus.start && state_r == ENG_IDLE) begin
            we_r <= bus.we;
            addr_r <= bus.addr;
            wdata_r <= bus.wdata;
         end
         done_r <= finish;
         if (finish) err_r <= rb_err;
         if (finish && !we_r) rdata_r <= rb_rdata;
      end
   end

   // bus outputs
   assign rb_req = (state_r == ENG_BUS);
   assign rb_we = we_r;
   assign rb_addr = addr_r;
   assign rb_wdata = wdata_r;
   assign bus.done = done_r;
   assign bus.err = err_r;
   assign bus.rdata = rdata_r;

endmodule : ipsp_rbus_eng

// >>> ipsp_periph_space.sv
// slave peripheral address space: pointer, mapped registers, indirect access
// Functional notes
// [RULE_01] bytes 0x00-0x03 hold the aligned target address for indirect writes
// [RULE_02] writing byte 0x07 sends the whole write-data word over the internal bus
// [RULE_03] after writing byte 0x07 the pointer goes back to 0x04
// [RULE_04] reading byte 0x07 advances to 0x08 and starts no write
// [RULE_05] bytes 0x10-0x13 hold the aligned source address for indirect reads
// [RULE_06] reading byte 0x14 fetches the word first, then returns its low byte
// [RULE_07] after reading byte 0x17 the pointer goes back to 0x14
// [RULE_08] read-data bytes are read only; writing 0x17 advances to 0x18
// [RULE_09] reserved ranges map to no register
// [RULE_10] access at byte 0xFF wraps the pointer to 0x00
// [RULE_11] bytes 0x20-0x23 are a read-only access status word
// [RULE_12] bytes 0x24-0x27 are a read/write control word for indirect access
// [RULE_13] bytes 0x80-0x83 show the internal status summary, read only
// [RULE_14] bytes 0x84-0x87 are enables letting summary bits set the alert flag
// [RULE_15] bytes 0x90-0x93 are an outgoing mailbox, written by the processor
// [RULE_16] bytes 0x94-0x97 are an incoming mailbox written by the master
// [RULE_17] the master sends the pointer byte first in every write
// [RULE_18] otherwise the pointer increments after every byte read or written
// [RULE_19] unmapped bytes read zero; writes there only advance the pointer
// [RULE_20] lowest byte address selects the least significant byte of a word
// [RULE_21] clock held low while an internal bus access is in progress
// [RULE_22] the pointer is cleared to zero by reset
`timescale 1ns/10ps
module ipsp_periph_space
   import ipsp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // byte stream from the slave protocol engine
   input wire logic ptr_load,
   input wire logic [7:0] ptr_value,
   input wire logic wr_strobe,
   input wire logic [7:0] wr_byte,
   input wire logic rd_strobe,
   output logic rd_valid,
   output logic [7:0] rd_byte,
   output logic scl_hold,
   output logic [7:0] peripheral_pointer,
   // internal register bus
   output logic rb_req,
   output logic rb_we,
   output logic [31:0] rb_addr,
   output logic [31:0] rb_wdata,
   input wire logic rb_ack,
   input wire logic rb_err,
   input wire logic [31:0] rb_rdata,
   // processor side
   input wire logic mbox_out_we,
   input wire logic [31:0] mbox_out_data,
   output logic [31:0] mbox_in_data,
   output logic mbox_in_full,
   input wire logic mbox_in_ack,
   input wire logic [31:0] status_summary_in,
   input wire logic alert_clear,
   output logic alert_flag,
   output logic [31:0] access_control
);

   // ======================================================
   // reset release through two flops
   logic rst_meta_r;
   logic rst_sync_r;
   logic rst_core_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   assign rst_core_n = rst_sync_r;

   // ======================================================
   // registers
   logic [7:0] ptr_r, ptr_nxt;
   logic [31:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [31:0] raddr_r, raddr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [31:0] aen_r, aen_nxt;
   logic [31:0] mbout_r, mbout_nxt;
   logic [31:0] mbin_r, mbin_nxt;
   logic alert_r, alert_nxt;
   logic wr_ok_r, wr_ok_nxt;
   logic rd_ok_r, rd_ok_nxt;
   logic err_r, err_nxt;
   logic deny_r, deny_nxt;
   logic mbout_full_r, mbout_full_nxt;
   logic mbin_full_r, mbin_full_nxt;
   logic pend_r, pend_nxt;
   logic pend_rd_r, pend_rd_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic [7:0] rd_byte_r, rd_byte_nxt;

   ipsp_rbus_if rbus ();

   ipsp_rbus_eng u_eng (
      .clk(clk),
      .rst_core_n(rst_core_n),
      .bus(rbus.eng),
      .rb_req(rb_req),
      .rb_we(rb_we),
      .rb_addr(rb_addr),
      .rb_wdata(rb_wdata),
      .rb_ack(rb_ack),
      .rb_err(rb_err),
      .rb_rdata(rb_rdata)
   );

   // overlay one byte lane of a word
   function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] l,
                                            input logic [7:0] b);
      logic [31:0] r;
      r = w;
      r[{l, 3'b000} +: 8] = b;
      return r;
   endfunction : put_byte

   // ======================================================
   // request acceptance; nothing is taken while the clock is stretched
   logic idle, ptr_take, wr_take, rd_take;
   assign idle = !pend_r;
   assign ptr_take = ptr_load & idle;
   assign wr_take = wr_strobe & idle & !ptr_load;
   assign rd_take = rd_strobe & idle & !ptr_load & !wr_strobe;

   // ======================================================
   // address decode, word index and lane
   logic [5:0] wsel;
   logic [1:0] lane;
   logic hit_waddr, hit_wdata, hit_raddr, hit_rdata, hit_astat, hit_actrl;
   logic hit_summ, hit_aen, hit_mbout, hit_mbin, hit_any;
   assign wsel = ptr_r[7:2];
   assign lane = ptr_r[1:0];
   assign hit_waddr = (wsel == OFS_WADDR[7:2]);
   assign hit_wdata = (wsel == OFS_WDATA[7:2]);
   assign hit_raddr = (wsel == OFS_RADDR[7:2]);
   assign hit_rdata = (wsel == OFS_RDATA[7:2]);
   assign hit_astat = (wsel == OFS_ASTAT[7:2]);
   assign hit_actrl = (wsel == OFS_ACTRL[7:2]);
   assign hit_summ = (wsel == OFS_SUMM[7:2]);
   assign hit_aen = (wsel == OFS_AEN[7:2]);
   assign hit_mbout = (wsel == OFS_MBOUT[7:2]);
   assign hit_mbin = (wsel == OFS_MBIN[7:2]);
   assign hit_any = hit_waddr | hit_wdata | hit_raddr | hit_rdata | hit_astat
                  | hit_actrl | hit_summ | hit_aen | hit_mbout | hit_mbin; // RULE_09

   // ======================================================
   // indirect access launch; a disabled access is recorded, not performed
   logic at_wmsb, at_rmsb, at_rlsb;
   logic wr_go, wr_deny, rd_go, rd_deny, rd_local, fetch_done, auto_inc;
   assign at_wmsb = (ptr_r == PTR_WDATA_MSB);
   assign at_rmsb = (ptr_r == PTR_RDATA_MSB);
   assign at_rlsb = (ptr_r == OFS_RDATA);
   assign wr_go = wr_take & at_wmsb & ctrl_r[CTRL_WR_EN_BIT]; // RULE_02 RULE_12
   assign wr_deny = wr_take & at_wmsb & !ctrl_r[CTRL_WR_EN_BIT];
   assign rd_go = rd_take & at_rlsb & ctrl_r[CTRL_RD_EN_BIT]; // RULE_06 RULE_12
   assign rd_deny = rd_take & at_rlsb & !ctrl_r[CTRL_RD_EN_BIT];
   assign rd_local = rd_take & !rd_go; // RULE_04
   assign fetch_done = rbus.done & pend_rd_r;
   assign auto_inc = ctrl_r[CTRL_AUTO_INC_BIT];

   // aligned addresses, lane 3 byte merged into the word on the way out
   assign rbus.start = wr_go | rd_go;
   assign rbus.we = wr_go;
   assign rbus.addr = wr_go ? {waddr_r[31:2], 2'b00} : {raddr_r[31:2], 2'b00}; // RULE_01 RULE_05
   assign rbus.wdata = put_byte(wdata_r, lane, wr_byte); // RULE_02

   // ======================================================
   // pointer movement with its three exceptions
   logic [7:0] ptr_adv, ptr_after_wr, ptr_after_rd;
   assign ptr_adv = (ptr_r == PTR_LAST) ? PTR_WRAP : ptr_r + PTR_STEP; // RULE_10 RULE_18
   assign ptr_after_wr = at_wmsb ? OFS_WDATA : ptr_adv; // RULE_03 RULE_08
   assign ptr_after_rd = at_rmsb ? OFS_RDATA : ptr_adv; // RULE_07
   // a fetching read advances only once the word is in
   assign ptr_nxt = ptr_take ? ptr_value :
                    wr_take ? ptr_after_wr :
                    (rd_local | fetch_done) ? ptr_after_rd : ptr_r; // RULE_18 RULE_19

   // ======================================================
   // read side: access status word and byte select
   logic [31:0] stat_word, rd_word;
   logic [7:0] rd_sel_byte;
   always_comb begin
      stat_word = WORD_RESET;
      stat_word[STAT_ALERT_BIT] = alert_r;
      stat_word[STAT_WR_OK_BIT] = wr_ok_r;
      stat_word[STAT_RD_OK_BIT] = rd_ok_r;
      stat_word[STAT_BUS_ERR_BIT] = err_r;
      stat_word[STAT_DENIED_BIT] = deny_r;
      stat_word[STAT_MBOUT_FULL_BIT] = mbout_full_r;
      stat_word[STAT_MBIN_FULL_BIT] = mbin_full_r; // RULE_11
   end

   assign rd_word = hit_waddr ? waddr_r :
                    hit_wdata ? wdata_r :
                    hit_raddr ? raddr_r :
                    hit_rdata ? rdata_r :
                    hit_astat ? stat_word : // RULE_11
                    hit_actrl ? ctrl_r :
                    hit_summ ? status_summary_in : // RULE_13
                    hit_aen ? aen_r :
                    hit_mbout ? mbout_r : // RULE_15
                    hit_mbin ? mbin_r : WORD_RESET; // RULE_19
   assign rd_sel_byte = rd_word[{lane, 3'b000} +: 8]; // RULE_20

   // ======================================================
   // byte writes; read-only words simply ignore them
   logic [31:0] wr_merge;
   assign wr_merge = put_byte(rd_word, lane, wr_byte); // RULE_20
   assign waddr_nxt = (wr_take & hit_waddr) ? wr_merge :
                      (rbus.done & !pend_rd_r & auto_inc) ? waddr_r + ADDR_STEP : waddr_r;
   assign wdata_nxt = (wr_take & hit_wdata) ? wr_merge : wdata_r;
   assign raddr_nxt = (wr_take & hit_raddr) ? wr_merge :
                      (fetch_done & auto_inc) ? raddr_r + ADDR_STEP : raddr_r;
   assign rdata_nxt = fetch_done ? rbus.rdata : rdata_r; // RULE_06 RULE_08
   assign ctrl_nxt = (wr_take & hit_actrl) ? wr_merge : ctrl_r; // RULE_12
   assign aen_nxt = (wr_take & hit_aen) ? wr_merge : aen_r; // RULE_14
   assign mbout_nxt = mbox_out_we ? mbox_out_data : mbout_r; // RULE_15
   assign mbin_nxt = (wr_take & hit_mbin) ? wr_merge : mbin_r; // RULE_16

   // ======================================================
   // sticky status; a set in the clearing cycle wins
   logic alert_set, res_clr, mbout_take, mbin_fill;
   assign alert_set = |(status_summary_in & aen_r); // RULE_14
   assign res_clr = rd_local & (ptr_r == OFS_ASTAT);
   assign mbout_take = rd_local & (ptr_r == PTR_MBOUT_MSB);
   assign mbin_fill = wr_take & (ptr_r == PTR_MBIN_MSB); // RULE_16
   assign alert_nxt = alert_set | (alert_r & !alert_clear); // RULE_14
   assign wr_ok_nxt = (rbus.done & !pend_rd_r & !rbus.err) | (wr_ok_r & !res_clr);
   assign rd_ok_nxt = (fetch_done & !rbus.err) | (rd_ok_r & !res_clr);
   assign err_nxt = (rbus.done & rbus.err) | (err_r & !res_clr);
   assign deny_nxt = wr_deny | rd_deny | (deny_r & !res_clr);
   assign mbout_full_nxt = mbox_out_we | (mbout_full_r & !mbout_take);
   assign mbin_full_nxt = mbin_fill | (mbin_full_r & !mbox_in_ack);

   // ======================================================
   // stretch and answer; stretch lasts from launch to done
   assign pend_nxt = rbus.start | (pend_r & !rbus.done); // RULE_21
   assign pend_rd_nxt = rd_go | (pend_rd_r & !rbus.done);
   assign rd_valid_nxt = rd_local | fetch_done;
   assign rd_byte_nxt = fetch_done ? rbus.rdata[7:0] :
                        rd_local ? rd_sel_byte : rd_byte_r; // RULE_06 RULE_19

   // pointer and indirect access words
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         ptr_r <= PTR_RESET; // RULE_22
         waddr_r <= WORD_RESET;
         wdata_r <= WORD_RESET;
         raddr_r <= WORD_RESET;
         rdata_r <= WORD_RESET;
      end else begin
         ptr_r <= ptr_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         raddr_r <= raddr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // control, enables and mailboxes
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         ctrl_r <= CTRL_RESET;
         aen_r <= WORD_RESET;
         mbout_r <= WORD_RESET;
         mbin_r <= WORD_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
         aen_r <= aen_nxt;
         mbout_r <= mbout_nxt;
         mbin_r <= mbin_nxt;
      end
   end

   // status flags
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         {alert_r, wr_ok_r, rd_ok_r, err_r} <= 4'h0;
         {deny_r, mbout_full_r, mbin_full_r} <= 3'h0;
      end else begin
         {alert_r, wr_ok_r, rd_ok_r, err_r} <= {alert_nxt, wr_ok_nxt, rd_ok_nxt, err_nxt};
         {deny_r, mbout_full_r, mbin_full_r} <= {deny_nxt, mbout_full_nxt, mbin_full_nxt};
      end
   end

   // handshake state and answer byte
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         pend_r <= 1'b0;
         pend_rd_r <= 1'b0;
         rd_valid_r <= 1'b0;
         rd_byte_r <= 8'h00;
      end else begin
         pend_r <= pend_nxt;
         pend_rd_r <= pend_rd_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_byte_r <= rd_byte_nxt;
      end
   end

   // ======================================================
   // outputs
   assign rd_valid = rd_valid_r;
   assign rd_byte = rd_byte_r;
   assign scl_hold = pend_r; // RULE_21
   assign peripheral_pointer = ptr_r;
   assign mbox_in_data = mbin_r;
   assign mbox_in_full = mbin_full_r;
   assign alert_flag = alert_r;
   assign access_control = ctrl_r;

   // ======================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_core_n);

   a_wdata_ptr_return: assert property ( // RULE_03
      wr_take && ptr_r == 8'h07 |=> ptr_r == 8'h04)
      else $error("pointer did not return to 0x04 after write of 0x07");
   a_rdata_ptr_return: assert property ( // RULE_07
      rd_local && ptr_r == 8'h17 |=> ptr_r == 8'h14)
      else $error("pointer did not return to 0x14 after read of 0x17");
   a_ptr_top_wrap: assert property ( // RULE_10
      (wr_take || rd_local) && ptr_r == 8'hFF |=> ptr_r == 8'h00)
      else $error("pointer did not wrap at 0xFF");
   a_ptr_plain_incr: assert property ( // RULE_18
      wr_take && ptr_r != 8'h07 && ptr_r != 8'hFF |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("pointer did not increment after write");
   a_write_launch_addr: assert property ( // RULE_02 RULE_01
      wr_take && ptr_r == 8'h07 && ctrl_r[0]
      |=> rb_req && rb_we && rb_addr == {$past(waddr_r[31:2]), 2'b00}
          && rb_wdata[31:24] == $past(wr_byte))
      else $error("write of 0x07 did not launch the expected bus write");
   a_read07_no_write: assert property ( // RULE_04
      rd_take && ptr_r == 8'h07 |=> ptr_r == 8'h08 && !rb_req && rd_valid)
      else $error("read of 0x07 misbehaved");
   a_fetch_then_byte: assert property ( // RULE_06
      fetch_done |=> rd_valid && rd_byte == $past(rbus.rdata[7:0])
      && rdata_r == $past(rbus.rdata) && ptr_r == 8'h15)
      else $error("fetched word not returned on low byte");
   a_fetch_no_early: assert property ( // RULE_06 RULE_21
      rd_go |=> scl_hold && !rd_valid ##1 !rd_valid)
      else $error("byte answered before fetch finished");
   a_hold_during_bus: assert property ( // RULE_21
      rb_req |-> scl_hold)
      else $error("clock not held during internal access");
   a_rdata_read_only: assert property ( // RULE_08
      wr_take && hit_rdata |=> $stable(rdata_r) && !rb_req)
      else $error("read data changed by a write");
   a_reserved_zero: assert property ( // RULE_19 RULE_09
      rd_local && !hit_any |=> rd_valid && rd_byte == 8'h00)
      else $error("unmapped byte did not read zero");
   a_alert_from_enable: assert property ( // RULE_14
      alert_set |=> alert_flag)
      else $error("enabled summary bit did not set alert");

   c_fetch_done: cover property (rd_go ##[1:20] rd_valid);
   c_write_stream: cover property (wr_go ##[1:40] wr_go);
   c_ptr_wrap: cover property ((wr_take || rd_local) && ptr_r == 8'hFF);
   c_mbox_in_full: cover property (mbin_fill);

endmodule : ipsp_periph_space

// >>> ipsp_rbus_model.sv
// register bus responder standing in for the device's internal registers
`timescale 1ns/10ps
module ipsp_rbus_model (
   // clock and request
   input wire logic clk,
   input wire logic rb_req,
   input wire logic rb_we,
   input wire logic [31:0] rb_addr,
   input wire logic [31:0] rb_wdata,
   input wire logic [3:0] lat,
   // answer and observation
   output logic rb_ack,
   output logic rb_err,
   output logic [31:0] rb_rdata,
   output logic [31:0] last_addr,
   output int n_wr
);
   logic [31:0] mem_r [16];
   int cnt;
   initial begin
      rb_ack = 1'b0;
      rb_err = 1'b0;
      rb_rdata = 32'h0;
      last_addr = 32'h0;
      n_wr = 0;
      cnt = 0;
   end
   // answer after lat wait cycles; idle data toggles so stale words never pass
   always @(posedge clk) begin
      rb_ack <= 1'b0;
      if (rb_req && !rb_ack && cnt >= lat) begin
         rb_ack <= 1'b1;
         cnt <= 0;
         last_addr <= rb_addr;
         rb_rdata <= mem_r[rb_addr[5:2]];
         if (rb_we) begin
            mem_r[rb_addr[5:2]] <= rb_wdata;
            n_wr <= n_wr + 1;
         end
      end else begin
         rb_rdata <= ~rb_rdata;
         if (rb_req && !rb_ack) cnt <= cnt + 1;
      end
   end
endmodule : ipsp_rbus_model

// >>> ipsp_periph_space_tb.sv
// self-checking bench for the peripheral space block
`timescale 1ns/10ps
module ipsp_periph_space_tb;
   import ipsp_pkg::*;
   logic clk, rst_n, ptr_load, wr_strobe, rd_strobe, rd_valid, scl_hold, rb_req, rb_we;
   logic rb_ack, rb_err, mbox_out_we, mbox_in_full, mbox_in_ack, alert_clear, alert_flag;
   logic [7:0] ptr_value, wr_byte, rd_byte, peripheral_pointer;
   logic [31:0] rb_addr, rb_wdata, rb_rdata, mbox_out_data, mbox_in_data, last_addr;
   logic [31:0] status_summary_in, access_control;
   logic [3:0] lat;
   int n_wr, failures, samples_checked;
   ipsp_periph_space DUT (.clk(clk), .rst_n(rst_n), .ptr_load(ptr_load),
      .ptr_value(ptr_value), .wr_strobe(wr_strobe), .wr_byte(wr_byte), .rd_strobe(rd_strobe),
      .rd_valid(rd_valid), .rd_byte(rd_byte), .scl_hold(scl_hold),
      .peripheral_pointer(peripheral_pointer), .rb_req(rb_req), .rb_we(rb_we),
      .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_ack(rb_ack), .rb_err(rb_err),
      .rb_rdata(rb_rdata), .mbox_out_we(mbox_out_we), .mbox_out_data(mbox_out_data),
      .mbox_in_data(mbox_in_data), .mbox_in_full(mbox_in_full), .mbox_in_ack(mbox_in_ack),
      .status_summary_in(status_summary_in), .alert_clear(alert_clear),
      .alert_flag(alert_flag), .access_control(access_control));
   ipsp_rbus_model u_bus (.clk(clk), .rb_req(rb_req), .rb_we(rb_we), .rb_addr(rb_addr),
      .rb_wdata(rb_wdata), .lat(lat), .rb_ack(rb_ack), .rb_err(rb_err), .rb_rdata(rb_rdata),
      .last_addr(last_addr), .n_wr(n_wr));
   // ==========================================
   // shared drivers; inputs move 1 ns after the edge
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic finish_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic set_ptr(input logic [7:0] p);
      ptr_load = 1'b1;
      ptr_value = p;
      step();
      ptr_load = 1'b0;
   endtask : set_ptr
   // strobes are ignored while stretched, so wait out any hold
   task automatic wr(input logic [7:0] b);
      int n = 0;
      wr_strobe = 1'b1;
      wr_byte = b;
      step();
      wr_strobe = 1'b0;
      // at least one edge with the strobe low, so back-to-back bytes stay separate pulses
      do begin
         step();
         n++;
      end while (scl_hold !== 1'b0 && n < 60);
      if (n == 60) begin
         failures++;
         finish_test();
      end
   endtask : wr
   task automatic rd(input logic [7:0] e);
      int n = 0;
      rd_strobe = 1'b1;
      step();
      rd_strobe = 1'b0;
      while (rd_valid !== 1'b1 && n < 60) begin
         step();
         n++;
      end
      if (n == 60) begin
         failures++;
         finish_test();
      end
      chk({24'h0, rd_byte}, {24'h0, e});
      step();
   endtask : rd
   // lane 0 travels first
   task automatic wr_word(input logic [31:0] w);
      for (int i = 0; i < 4; i++) wr(w[8*i +: 8]);
   endtask : wr_word
   task automatic rd_word(input logic [31:0] w);
      for (int i = 0; i < 4; i++) rd(w[8*i +: 8]);
   endtask : rd_word
   // ==========================================
   // scenarios
   task automatic t_indirect();
      set_ptr(OFS_WADDR);
      wr_word(32'h0000_0008);
      wr_word(32'h1122_3344);
      chk({24'h0, peripheral_pointer}, {24'h0, OFS_WDATA});
      chk(last_addr, 32'h0000_0008);
      wr_word(32'h5566_7788);
      chk(n_wr, 32'h2);
      lat = 4'h3;
      set_ptr(OFS_RADDR);
      wr_word(32'h0000_0008);
      set_ptr(OFS_RDATA);
      rd_word(32'h5566_7788);
      chk({24'h0, peripheral_pointer}, {24'h0, OFS_RDATA});
      rd_word(32'h5566_7788);
   endtask : t_indirect
   task automatic t_pointer();
      logic [7:0] rsv [5] = '{8'h0C, 8'h1F, 8'h40, 8'h88, 8'hC0};
      set_ptr(PTR_WDATA_MSB);
      rd(8'h55);
      chk({24'h0, peripheral_pointer}, 32'h08);
      set_ptr(PTR_RDATA_MSB);
      wr(8'hA5);
      chk({24'h0, peripheral_pointer}, 32'h18);
      set_ptr(PTR_RDATA_MSB);
      rd(8'h55);
      for (int i = 0; i < 5; i++) begin
         set_ptr(rsv[i]);
         wr(8'hFF);
         set_ptr(rsv[i]);
         rd(8'h00);
      end
      set_ptr(PTR_LAST);
      wr(8'h5A);
      chk({24'h0, peripheral_pointer}, 32'h00);
      rd(8'h08);
      chk(n_wr, 32'h2);
   endtask : t_pointer
   task automatic t_regs();
      mbox_out_we = 1'b1;
      step();
      mbox_out_we = 1'b0;
      set_ptr(OFS_MBOUT);
      rd_word(32'hC0DE_1234);
      wr_word(32'h0BAD_F00D);
      chk(mbox_in_data, 32'h0BAD_F00D);
      chk({31'h0, mbox_in_full}, 32'h1);
      set_ptr(OFS_ACTRL);
      wr_word(32'h0000_0007);
      chk(access_control, 32'h0000_0007);
      set_ptr(OFS_AEN);
      wr_word(32'h0000_0001);
      status_summary_in = 32'h0000_0001;
      step();
      step();
      chk({31'h0, alert_flag}, 32'h1);
      set_ptr(OFS_SUMM);
      rd_word(32'h0000_0001);
      set_ptr(OFS_ASTAT);
      rd(8'h47);
      set_ptr(OFS_ASTAT);
      rd(8'h41);
      // processor takes the message and clears the alert once the summary is quiet
      mbox_in_ack = 1'b1;
      alert_clear = 1'b1;
      status_summary_in = 32'h0;
      step();
      {mbox_in_ack, alert_clear} = 2'b00;
      chk({31'h0, mbox_in_full}, 32'h0);
      chk({31'h0, alert_flag}, 32'h0);
   endtask : t_regs
   // ==========================================
   // main sequence
   initial begin
      {rst_n, ptr_load, wr_strobe, rd_strobe, mbox_out_we, mbox_in_ack, alert_clear} = '0;
      {ptr_value, wr_byte, lat, status_summary_in} = '0;
      mbox_out_data = 32'hC0DE_1234;
      failures = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) step();
      chk({24'h0, peripheral_pointer}, 32'h00);
      chk(access_control, CTRL_RESET);
      t_indirect();
      t_pointer();
      t_regs();
      finish_test();
   end
endmodule : ipsp_periph_space_tb
